// ===== common/spp_pkg.sv
// Constants, register map and state type for the byte-wide slave port.
// Assumes a single clock domain and an AXI4-Lite master with 32-bit data.
// Function
// [R1] Select bit turns port into host slave
// [R2] Host accesses asynchronous, strobe controlled only
// [R3] Port E bits: read, write, select
// [R4] Software sets port E strobe bits input
// [R5] Write spans select and write strobe low
// [R6] Write end sets irq flag, input full
// [R7] Select and read low drive latch out
// [R8] CPU latch update shows on pins immediately
// [R9] Read end releases pins, sets irq flag
// [R10] Control bit 7 reads input full
// [R11] Control bit 6 reads output full
// [R12] Write over unread byte sets overflow
// [R13] Control bit 4 selects slave mode
// [R14] Control bits 3..0 read zero
// [R15] Irq flag, enable, priority at bit 7
// [R16] Slave port off while memory bus used
// [R17] Memory bus controls override port E pins
// [R18] Strobes synchronised before edge detection
// [R19] CPU read clears, write sets flags; the code clears overflow with a CPU control write that has bit 5 low
package spp_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int BYTE_W = 8;
  localparam int E_W = 3;
  localparam int SYNC_W = 11;
  // Register byte offsets
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_DATA = 8'h04;
  localparam logic [7:0] OFF_FLAG = 8'h08;
  localparam logic [7:0] OFF_ENABLE = 8'h0C;
  localparam logic [7:0] OFF_PRIORITY = 8'h10;
  localparam logic [7:0] OFF_PORT_E = 8'h14;
  localparam logic [7:0] OFF_PORT_D_DIR = 8'h18;
  // Register indices produced by the decoder
  localparam logic [2:0] IDX_CONTROL = 3'h0;
  localparam logic [2:0] IDX_DATA = 3'h1;
  localparam logic [2:0] IDX_FLAG = 3'h2;
  localparam logic [2:0] IDX_ENABLE = 3'h3;
  localparam logic [2:0] IDX_PRIORITY = 3'h4;
  localparam logic [2:0] IDX_PORT_E = 3'h5;
  localparam logic [2:0] IDX_PORT_D_DIR = 3'h6;
  localparam logic [2:0] IDX_NONE = 3'h7;
  // Field positions
  localparam int BIT_IN_FULL = 7;
  localparam int BIT_OUT_FULL = 6;
  localparam int BIT_OVERFLOW = 5;
  localparam int BIT_SELECT = 4;
  localparam int BIT_IRQ = 7;
  localparam int PORT_E_LATCH_LSB = 4;
  // Sync vector layout: strobes then data
  localparam int SYN_RD = 0;
  localparam int SYN_WR = 1;
  localparam int SYN_CS = 2;
  localparam int SYN_D_LSB = 3;
  // Reset values
  localparam logic [SYNC_W-1:0] SYNC_RESET = 11'h7FF;
  localparam logic [E_W-1:0] PORT_E_DIR_RESET = 3'h7;
  localparam logic [E_W-1:0] PORT_E_ALL_IN = 3'h7;
  localparam logic [BYTE_W-1:0] PORT_D_DIR_RESET = 8'hFF;
  localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic [BYTE_W-1:0] BYTE_ONES = 8'hFF;
  localparam logic [3:0] LOW_NIBBLE_ZERO = 4'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WRITE = 2'b01,
    ST_READ = 2'b10
  } spp_state_t;
endpackage : spp_pkg

// ===== hw/spp_slave_port.sv
// Byte-wide host slave port with AXI4-Lite register access.
// Assumes host strobes are asynchronous pins; the pad ring resolves
// the port D and port E output enables onto the shared wires.
module spp_slave_port (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [spp_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [spp_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [spp_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [spp_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [spp_pkg::BYTE_W-1:0] port_d_data_in,
  output logic [spp_pkg::BYTE_W-1:0] port_d_data_out,
  output logic [spp_pkg::BYTE_W-1:0] port_d_data_oe,
  input wire logic port_e_bit0_pin_in,
  input wire logic port_e_bit1_pin_in,
  input wire logic port_e_bit2_pin_in,
  output logic [spp_pkg::E_W-1:0] port_e_pin_out,
  output logic [spp_pkg::E_W-1:0] port_e_pin_oe,
  input wire logic ext_bus_active,
  input wire logic [spp_pkg::E_W-1:0] ext_bus_ctrl,
  output logic irq,
  output logic irq_priority
);

  function automatic logic [2:0] spp_decode(input logic [spp_pkg::ADDR_W-1:0] addr);
    logic [2:0] idx;
    idx = spp_pkg::IDX_NONE;
    case (addr)
      spp_pkg::OFF_CONTROL: idx = spp_pkg::IDX_CONTROL;
      spp_pkg::OFF_DATA: idx = spp_pkg::IDX_DATA;
      spp_pkg::OFF_FLAG: idx = spp_pkg::IDX_FLAG;
      spp_pkg::OFF_ENABLE: idx = spp_pkg::IDX_ENABLE;
      spp_pkg::OFF_PRIORITY: idx = spp_pkg::IDX_PRIORITY;
      spp_pkg::OFF_PORT_E: idx = spp_pkg::IDX_PORT_E;
      spp_pkg::OFF_PORT_D_DIR: idx = spp_pkg::IDX_PORT_D_DIR;
      default: idx = spp_pkg::IDX_NONE;
    endcase
    return idx;
  endfunction : spp_decode

  // Pin synchronisers: three stages, change accepted when stages two and three agree
  logic [spp_pkg::SYNC_W-1:0] sync_raw;
  logic [spp_pkg::SYNC_W-1:0] sync_s0;
  logic [spp_pkg::SYNC_W-1:0] sync_s1;
  logic [spp_pkg::SYNC_W-1:0] sync_s2;
  logic [spp_pkg::SYNC_W-1:0] sync_filt;

  assign sync_raw = {port_d_data_in, port_e_bit2_pin_in, port_e_bit1_pin_in, port_e_bit0_pin_in};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_s0 <= spp_pkg::SYNC_RESET;
      sync_s1 <= spp_pkg::SYNC_RESET;
      sync_s2 <= spp_pkg::SYNC_RESET;
    end else begin
      sync_s0 <= sync_raw; // [R2]
      sync_s1 <= sync_s0;
      sync_s2 <= sync_s1;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < spp_pkg::SYNC_W; gi++) begin : g_filt
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          sync_filt[gi] <= spp_pkg::SYNC_RESET[gi];
        end else if (sync_s1[gi] == sync_s2[gi]) begin
          sync_filt[gi] <= sync_s2[gi]; // [R18]
        end
      end
    end
  endgenerate

  logic rd_n_f;
  logic wr_n_f;
  logic cs_n_f;
  logic [spp_pkg::BYTE_W-1:0] d_in_f;
  assign rd_n_f = sync_filt[spp_pkg::SYN_RD]; // [R3]
  assign wr_n_f = sync_filt[spp_pkg::SYN_WR]; // [R3]
  assign cs_n_f = sync_filt[spp_pkg::SYN_CS]; // [R3]
  assign d_in_f = sync_filt[spp_pkg::SYN_D_LSB +: spp_pkg::BYTE_W];

  // Registers
  logic slave_port_select;
  logic input_buffer_full;
  logic output_buffer_full;
  logic input_overflow;
  logic slave_port_irq_flag;
  logic slave_port_irq_enable;
  logic slave_port_irq_priority;
  logic [spp_pkg::BYTE_W-1:0] port_d_output_latch;
  logic [spp_pkg::BYTE_W-1:0] input_byte;
  logic [spp_pkg::BYTE_W-1:0] port_d_direction;
  logic [spp_pkg::E_W-1:0] port_e_direction;
  logic [spp_pkg::E_W-1:0] port_e_latch;

  // AXI write channel
  logic aw_held;
  logic w_held;
  logic [spp_pkg::ADDR_W-1:0] aw_addr;
  logic [spp_pkg::DATA_W-1:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic [2:0] wr_idx;
  logic lane0;

  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign wr_idx = spp_decode(aw_addr);
  assign lane0 = w_strb[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= spp_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (wr_idx == spp_pkg::IDX_NONE) ? spp_pkg::RESP_SLVERR : spp_pkg::RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  logic ctrl_wr;
  logic data_wr;
  assign ctrl_wr = wr_fire && lane0 && (wr_idx == spp_pkg::IDX_CONTROL);
  assign data_wr = wr_fire && lane0 && (wr_idx == spp_pkg::IDX_DATA);

  // AXI read channel
  logic rd_fire;
  logic [2:0] rd_idx;
  logic data_rd;
  logic flag_rd;
  logic [spp_pkg::BYTE_W-1:0] rd_byte;

  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign rd_idx = spp_decode(s_axi_araddr);
  assign data_rd = rd_fire && (rd_idx == spp_pkg::IDX_DATA);
  assign flag_rd = rd_fire && (rd_idx == spp_pkg::IDX_FLAG);

  always_comb begin
    rd_byte = spp_pkg::BYTE_ZERO;
    unique case (rd_idx)
      spp_pkg::IDX_CONTROL: rd_byte = {input_buffer_full, output_buffer_full, input_overflow,
                                       slave_port_select, spp_pkg::LOW_NIBBLE_ZERO}; // [R10] [R11] [R14]
      spp_pkg::IDX_DATA: rd_byte = slave_port_select ? input_byte : d_in_f;
      spp_pkg::IDX_FLAG: rd_byte[spp_pkg::BIT_IRQ] = slave_port_irq_flag; // [R15]
      spp_pkg::IDX_ENABLE: rd_byte[spp_pkg::BIT_IRQ] = slave_port_irq_enable; // [R15]
      spp_pkg::IDX_PRIORITY: rd_byte[spp_pkg::BIT_IRQ] = slave_port_irq_priority; // [R15]
      spp_pkg::IDX_PORT_E: rd_byte = {1'b0, port_e_latch, 1'b0, port_e_direction};
      spp_pkg::IDX_PORT_D_DIR: rd_byte = port_d_direction;
      spp_pkg::IDX_NONE: rd_byte = spp_pkg::BYTE_ZERO;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= spp_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_byte};
      s_axi_rresp <= (rd_idx == spp_pkg::IDX_NONE) ? spp_pkg::RESP_SLVERR : spp_pkg::RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Software configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      slave_port_select <= 1'b0;
      slave_port_irq_enable <= 1'b0;
      slave_port_irq_priority <= 1'b0;
      port_e_direction <= spp_pkg::PORT_E_DIR_RESET;
      port_e_latch <= '0;
      port_d_direction <= spp_pkg::PORT_D_DIR_RESET;
      port_d_output_latch <= spp_pkg::BYTE_ZERO;
    end else if (wr_fire && lane0) begin
      unique case (wr_idx)
        spp_pkg::IDX_CONTROL: slave_port_select <= w_data[spp_pkg::BIT_SELECT]; // [R13]
        spp_pkg::IDX_DATA: port_d_output_latch <= w_data[spp_pkg::BYTE_W-1:0];
        spp_pkg::IDX_ENABLE: slave_port_irq_enable <= w_data[spp_pkg::BIT_IRQ]; // [R15]
        spp_pkg::IDX_PRIORITY: slave_port_irq_priority <= w_data[spp_pkg::BIT_IRQ]; // [R15]
        spp_pkg::IDX_PORT_E: begin
          port_e_direction <= w_data[spp_pkg::E_W-1:0];
          port_e_latch <= w_data[spp_pkg::PORT_E_LATCH_LSB +: spp_pkg::E_W];
        end
        spp_pkg::IDX_PORT_D_DIR: port_d_direction <= w_data[spp_pkg::BYTE_W-1:0];
        spp_pkg::IDX_FLAG, spp_pkg::IDX_NONE: begin
        end
      endcase
    end
  end

  // Host access sequencer
  logic port_active;
  logic write_end;
  logic read_end;
  spp_pkg::spp_state_t state;
  spp_pkg::spp_state_t next_state;

  // Strobe pins must be inputs and the memory bus idle
  assign port_active = slave_port_select && !ext_bus_active
                       && (port_e_direction == spp_pkg::PORT_E_ALL_IN); // [R1] [R4] [R16]
  assign write_end = (state == spp_pkg::ST_WRITE) && (cs_n_f || wr_n_f || !port_active); // [R5]
  assign read_end = (state == spp_pkg::ST_READ) && (cs_n_f || rd_n_f || !port_active); // [R9]

  always_comb begin
    next_state = state;
    unique case (state)
      spp_pkg::ST_IDLE: begin
        if (port_active && !cs_n_f && !wr_n_f) begin
          next_state = spp_pkg::ST_WRITE; // [R5]
        end else if (port_active && !cs_n_f && !rd_n_f) begin
          next_state = spp_pkg::ST_READ; // [R7]
        end
      end
      spp_pkg::ST_WRITE: if (write_end) next_state = spp_pkg::ST_IDLE;
      spp_pkg::ST_READ: if (read_end) next_state = spp_pkg::ST_IDLE;
      default: next_state = spp_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= spp_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Data latched at write end, once the filtered strobes rise; end is seen after the data settled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      input_byte <= spp_pkg::BYTE_ZERO;
    end else if (write_end) begin
      input_byte <= d_in_f;
    end
  end

  // Status flags: a set wins over a same-cycle clear, whether the set comes from hardware or from a CPU write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      input_buffer_full <= 1'b0;
    end else if (write_end) begin
      input_buffer_full <= 1'b1; // [R6]
    end else if (data_rd) begin
      input_buffer_full <= 1'b0; // [R19]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      output_buffer_full <= 1'b0;
    end else if (data_wr) begin
      output_buffer_full <= 1'b1; // [R19]
    end else if (state == spp_pkg::ST_IDLE && next_state == spp_pkg::ST_READ) begin
      output_buffer_full <= 1'b0; // [R11]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      input_overflow <= 1'b0;
    end else if (write_end && input_buffer_full && !data_rd) begin
      input_overflow <= 1'b1; // [R12]
    end else if (ctrl_wr && !w_data[spp_pkg::BIT_OVERFLOW]) begin
      input_overflow <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      slave_port_irq_flag <= 1'b0;
    end else if (write_end || read_end) begin
      slave_port_irq_flag <= 1'b1; // [R6] [R9]
    end else if (flag_rd) begin
      slave_port_irq_flag <= 1'b0;
    end
  end

  assign irq = slave_port_irq_flag && slave_port_irq_enable;
  assign irq_priority = slave_port_irq_priority;

  // Pins: latch is driven straight out so a late CPU write shows at once
  assign port_d_data_out = port_d_output_latch; // [R8]
  always_comb begin
    if (slave_port_select) begin
      port_d_data_oe = (state == spp_pkg::ST_READ) ? spp_pkg::BYTE_ONES
                                                    : spp_pkg::BYTE_ZERO; // [R7] [R9]
    end else begin
      port_d_data_oe = ~port_d_direction;
    end
  end

  always_comb begin
    if (ext_bus_active) begin
      port_e_pin_out = ext_bus_ctrl; // [R17]
      port_e_pin_oe = spp_pkg::PORT_E_ALL_IN;
    end else begin
      port_e_pin_out = port_e_latch;
      port_e_pin_oe = ~port_e_direction;
    end
  end

  // Checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  chk_write_end_flags: assert property ( // [R6]
    write_end |=> input_buffer_full && slave_port_irq_flag)
    else $error("write end did not set full and irq flags");

  chk_overflow_set: assert property ( // [R12]
    (write_end && input_buffer_full && !data_rd) |=> input_overflow)
    else $error("overwrite of unread byte did not set overflow");

  // Read start seen on the filtered pins must turn the drivers on next cycle
  chk_read_drives: assert property ( // [R7]
    (state == spp_pkg::ST_IDLE && port_active && !cs_n_f && wr_n_f && !rd_n_f && !ctrl_wr)
    |=> port_d_data_oe == spp_pkg::BYTE_ONES)
    else $error("port not driven after host read start");

  chk_read_release: assert property ( // [R9]
    (read_end && !ctrl_wr) |=> port_d_data_oe == spp_pkg::BYTE_ZERO && slave_port_irq_flag)
    else $error("read end did not release pins or flag");

  chk_latch_live: assert property ( // [R8]
    (data_wr && state == spp_pkg::ST_READ && !read_end)
    |=> port_d_data_out == $past(w_data[spp_pkg::BYTE_W-1:0]))
    else $error("new latch value not on pins during read");

  chk_reserved_zero: assert property ( // [R14]
    (rd_fire && rd_idx == spp_pkg::IDX_CONTROL) |=> s_axi_rdata[3:0] == 4'h0)
    else $error("reserved control bits not zero");

  chk_out_full_set: assert property ( // [R19]
    data_wr |=> output_buffer_full)
    else $error("latch write did not set output full");

  chk_write_start: assert property ( // [R5]
    (state == spp_pkg::ST_IDLE && port_active && !cs_n_f && !wr_n_f)
    |=> state == spp_pkg::ST_WRITE)
    else $error("write not started on select and strobe low");

  chk_strobe_sync: assert property ( // [R18]
    $changed(cs_n_f) |-> cs_n_f == $past(port_e_bit2_pin_in, 4))
    else $error("select change not aligned to synchroniser delay");

  // Memory bus use must also end an access already in progress
  chk_mode_gate: assert property ( // [R16]
    ext_bus_active |=> state == spp_pkg::ST_IDLE)
    else $error("host access active while memory bus in use");

endmodule : spp_slave_port

// ===== testbench/spp_host_model.sv
// Model of the external processor that reads and writes the slave port.
// Assumes one-cycle go pulses from the bench, issued only while busy is low.
module spp_host_model (
  input wire logic aclk,
  input wire logic go_wr,
  input wire logic go_rd,
  input wire logic [7:0] wbyte,
  input wire logic [7:0] dev_out,
  input wire logic [7:0] dev_oe,
  output logic cs_n,
  output logic wr_n,
  output logic rd_n,
  output logic [7:0] bus,
  output logic busy,
  output logic rd_done,
  output logic [7:0] rbyte
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LOW_CYC = 8;
  localparam int GAP_CYC = 8;
  logic drive = 1'b0;
  logic [7:0] hdata = 8'h00;
  int cnt = 0;
  // Released lines show the inverse, so a stale byte never passes
  assign bus = (dev_oe & dev_out) | (~dev_oe & (drive ? hdata : ~hdata));
  initial begin
    cs_n = 1'b1;
    wr_n = 1'b1;
    rd_n = 1'b1;
    busy = 1'b0;
    rd_done = 1'b0;
    rbyte = 8'h00;
  end
  always @(posedge aclk) begin
    rd_done <= 1'b0;
    if (!busy && (go_wr || go_rd)) begin
      busy <= 1'b1;
      cnt <= 0;
      cs_n <= 1'b0;
      wr_n <= !go_wr;
      rd_n <= go_wr;
      drive <= go_wr;
      hdata <= wbyte;
    end else if (busy) begin
      cnt <= cnt + 1;
      if (cnt == LOW_CYC - 1) begin
        if (!rd_n) begin
          rbyte <= bus;
          rd_done <= 1'b1;
        end
        cs_n <= 1'b1;
        wr_n <= 1'b1;
        rd_n <= 1'b1;
      end
      // Data held past strobe rise to cover the slave's synchroniser
      if (cnt == LOW_CYC + 5) begin
        drive <= 1'b0;
      end
      if (cnt == LOW_CYC + GAP_CYC) begin
        busy <= 1'b0;
      end
    end
  end
endmodule : spp_host_model

// ===== testbench/spp_slave_port_tb_top.sv
// Self-checking bench: AXI4-Lite register traffic plus host port accesses.
// Assumes the host model above drives port D and the three port E strobes.
module spp_slave_port_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [spp_pkg::ADDR_W-1:0] s_axi_awaddr = 8'h00;
  logic [spp_pkg::ADDR_W-1:0] s_axi_araddr = 8'h00;
  logic [spp_pkg::DATA_W-1:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [spp_pkg::DATA_W-1:0] s_axi_rdata;
  logic [7:0] port_d_data_in, port_d_data_out, port_d_data_oe;
  logic port_e_bit0_pin_in, port_e_bit1_pin_in, port_e_bit2_pin_in;
  logic [2:0] port_e_pin_out, port_e_pin_oe;
  logic ext_bus_active = 1'b0;
  logic [2:0] ext_bus_ctrl = 3'h0;
  logic irq, irq_priority;
  logic go_wr = 1'b0, go_rd = 1'b0, h_busy, h_done;
  logic [7:0] h_wbyte = 8'h00, h_rbyte, rnd = 8'h02;
  logic [33:0] exp_q[$];
  int errors = 0, checks_done = 0;
  always #50 aclk = ~aclk;

  spp_slave_port spp_slave_port_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .port_d_data_in, .port_d_data_out,
    .port_d_data_oe, .port_e_bit0_pin_in, .port_e_bit1_pin_in, .port_e_bit2_pin_in,
    .port_e_pin_out, .port_e_pin_oe, .ext_bus_active, .ext_bus_ctrl, .irq, .irq_priority);

  spp_host_model spp_host_model_i (.aclk(aclk), .go_wr(go_wr), .go_rd(go_rd),
    .wbyte(h_wbyte), .dev_out(port_d_data_out), .dev_oe(port_d_data_oe),
    .cs_n(port_e_bit2_pin_in), .wr_n(port_e_bit1_pin_in), .rd_n(port_e_bit0_pin_in),
    .bus(port_d_data_in), .busy(h_busy), .rd_done(h_done), .rbyte(h_rbyte));

  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr

  task automatic test_done;
    $display("Checks %0d, errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done

  task automatic check(input logic [33:0] got, input logic [33:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic tick(inout int n);
    n++;
    if (n > 200) begin
      errors++;
      $display("MISMATCH at %0t: wait timed out, got %h expected %h", $time, 1'b0, 1'b1);
      test_done();
    end
  endtask : tick

  // Oldest note pairs with whichever result shows up
  always @(negedge aclk) begin
    logic [33:0] e;
    if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready) || h_done) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 34'h3FFFFFFFF;
      if (s_axi_bvalid) check({s_axi_bresp, 32'h0}, e);
      else if (s_axi_rvalid) check({s_axi_rresp, s_axi_rdata}, e);
      else check({26'h0, h_rbyte}, e);
    end
  end

  task automatic axi_wr(input logic [7:0] addr, input logic [7:0] data, input logic [1:0] resp);
    logic aw_p, w_p, a, w;
    int n;
    aw_p = 1'b1;
    w_p = 1'b1;
    n = 0;
    exp_q.push_back({resp, 32'h0});
    @(posedge aclk);
    s_axi_awaddr <= addr;
    s_axi_wdata <= {24'h0, data};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw_p || w_p) begin
      @(negedge aclk);
      a = s_axi_awready;
      w = s_axi_wready;
      @(posedge aclk);
      if (aw_p && a) begin
        s_axi_awvalid <= 1'b0;
        aw_p = 1'b0;
      end
      if (w_p && w) begin
        s_axi_wvalid <= 1'b0;
        w_p = 1'b0;
      end
      tick(n);
    end
    do begin @(negedge aclk); tick(n); end while (s_axi_bvalid !== 1'b1);
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] addr, input logic [7:0] data, input logic [1:0] resp);
    logic a;
    int n;
    n = 0;
    exp_q.push_back({resp, 24'h0, data});
    @(posedge aclk);
    s_axi_araddr <= addr;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin @(negedge aclk); a = s_axi_arready; @(posedge aclk); tick(n); end while (!a);
    s_axi_arvalid <= 1'b0;
    do begin @(negedge aclk); tick(n); end while (s_axi_rvalid !== 1'b1);
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  task automatic host_start(input logic wr, input logic [7:0] b);
    @(posedge aclk);
    go_wr <= wr;
    go_rd <= !wr;
    h_wbyte <= b;
    @(posedge aclk);
    go_wr <= 1'b0;
    go_rd <= 1'b0;
  endtask : host_start

  task automatic host_wait;
    int n;
    n = 0;
    do begin @(negedge aclk); tick(n); end while (h_busy !== 1'b0);
  endtask : host_wait

  task automatic host_op(input logic wr, input logic [7:0] b);
    if (!wr) exp_q.push_back({26'h0, b});
    host_start(wr, b);
    host_wait();
  endtask : host_op

  // Value is taken at the call: callers stand on a falling edge, except the final queue-size check after a read
  task automatic pin(input logic [7:0] got, input logic [7:0] exp);
    check({26'h0, got}, {26'h0, exp});
  endtask : pin

  localparam logic [7:0] OFFS [7] = '{spp_pkg::OFF_CONTROL, spp_pkg::OFF_DATA,
    spp_pkg::OFF_FLAG, spp_pkg::OFF_ENABLE, spp_pkg::OFF_PRIORITY, spp_pkg::OFF_PORT_E,
    spp_pkg::OFF_PORT_D_DIR};
  localparam logic [7:0] VALS [7] = '{8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h07, 8'hFF};

  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (OFFS[i]) axi_rd(OFFS[i], VALS[i], spp_pkg::RESP_OKAY);
    axi_rd(8'h1C, 8'h00, spp_pkg::RESP_SLVERR);
    axi_wr(8'h1C, 8'hFF, spp_pkg::RESP_SLVERR);
    // Port mode off: a host write must leave no trace
    host_op(1'b1, 8'h5A);
    axi_rd(spp_pkg::OFF_FLAG, 8'h00, spp_pkg::RESP_OKAY);
    axi_wr(spp_pkg::OFF_CONTROL, 8'hFF, spp_pkg::RESP_OKAY);
    axi_rd(spp_pkg::OFF_CONTROL, 8'h10, spp_pkg::RESP_OKAY);
    axi_wr(spp_pkg::OFF_ENABLE, 8'h80, spp_pkg::RESP_OKAY);
    axi_wr(spp_pkg::OFF_PRIORITY, 8'h80, spp_pkg::RESP_OKAY);
    @(negedge aclk);
    pin({7'h0, irq_priority}, 8'h01);
    repeat (3) begin
      rnd = lfsr(rnd);
      host_op(1'b1, rnd);
      pin({7'h0, irq}, 8'h01);
      axi_rd(spp_pkg::OFF_CONTROL, 8'h90, spp_pkg::RESP_OKAY);
      axi_rd(spp_pkg::OFF_FLAG, 8'h80, spp_pkg::RESP_OKAY);
      axi_rd(spp_pkg::OFF_FLAG, 8'h00, spp_pkg::RESP_OKAY);
      @(negedge aclk);
      pin({7'h0, irq}, 8'h00);
      axi_rd(spp_pkg::OFF_DATA, rnd, spp_pkg::RESP_OKAY);
    end
    // Second byte over an unread one
    host_op(1'b1, 8'h11);
    host_op(1'b1, 8'h22);
    axi_rd(spp_pkg::OFF_CONTROL, 8'hB0, spp_pkg::RESP_OKAY);
    axi_rd(spp_pkg::OFF_DATA, 8'h22, spp_pkg::RESP_OKAY);
    axi_rd(spp_pkg::OFF_CONTROL, 8'h30, spp_pkg::RESP_OKAY);
    axi_wr(spp_pkg::OFF_CONTROL, 8'h10, spp_pkg::RESP_OKAY);
    axi_rd(spp_pkg::OFF_CONTROL, 8'h10, spp_pkg::RESP_OKAY);
    axi_rd(spp_pkg::OFF_FLAG, 8'h80, spp_pkg::RESP_OKAY);
    axi_wr(spp_pkg::OFF_DATA, 8'hA5, spp_pkg::RESP_OKAY);
    axi_rd(spp_pkg::OFF_CONTROL, 8'h50, spp_pkg::RESP_OKAY);
    host_op(1'b0, 8'hA5);
    pin(port_d_data_oe, 8'h00);
    axi_rd(spp_pkg::OFF_CONTROL, 8'h10, spp_pkg::RESP_OKAY);
    axi_rd(spp_pkg::OFF_FLAG, 8'h80, spp_pkg::RESP_OKAY);
    // New latch value written once the port is in its read state
    host_start(1'b0, 8'h00);
    // Strobes need five edges to reach the read state; the host samples later
    repeat (3) @(posedge aclk);
    axi_wr(spp_pkg::OFF_DATA, 8'h3C, spp_pkg::RESP_OKAY);
    exp_q.push_back({26'h0, 8'h3C});
    host_wait();
    axi_rd(spp_pkg::OFF_FLAG, 8'h80, spp_pkg::RESP_OKAY);
    rnd = lfsr(rnd);
    @(posedge aclk);
    ext_bus_active <= 1'b1;
    ext_bus_ctrl <= rnd[2:0];
    @(negedge aclk);
    pin({5'h0, port_e_pin_oe}, 8'h07);
    pin({5'h0, port_e_pin_out}, {5'h0, rnd[2:0]});
    host_op(1'b1, 8'h77);
    axi_rd(spp_pkg::OFF_FLAG, 8'h00, spp_pkg::RESP_OKAY);
    @(posedge aclk);
    ext_bus_active <= 1'b0;
    axi_wr(spp_pkg::OFF_PORT_E, 8'h06, spp_pkg::RESP_OKAY);
    host_op(1'b1, 8'h66);
    axi_rd(spp_pkg::OFF_FLAG, 8'h00, spp_pkg::RESP_OKAY);
    axi_wr(spp_pkg::OFF_PORT_E, 8'h07, spp_pkg::RESP_OKAY);
    axi_wr(spp_pkg::OFF_ENABLE, 8'h00, spp_pkg::RESP_OKAY);
    host_op(1'b1, 8'h99);
    pin({7'h0, irq}, 8'h00);
    axi_rd(spp_pkg::OFF_FLAG, 8'h80, spp_pkg::RESP_OKAY);
    axi_rd(spp_pkg::OFF_DATA, 8'h99, spp_pkg::RESP_OKAY);
    pin(8'(exp_q.size()), 8'h00);
    test_done();
  end
endmodule : spp_slave_port_tb_top
